//--- src/bfs_flag_reg.sv
// Purpose: bus busy tracking, start failure and start setup register
// Assumes: op_enable and start_req come from controller logic on clk
// Notes:   each access takes two cycles; waitrequest is high for the first
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps

module bfs_flag_reg (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // avalon-mm slave
   input  wire logic [31:0] address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   // bus lines
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   // controller side
   input  wire logic        op_enable,
   input  wire logic        start_req,
   output logic             start_trigger_clr,
   output logic             start_allowed,
   output logic             reserve_enabled,
   // interrupt
   output logic             irq
);

   logic                      ack_reg;
   logic                      wr_fire;
   logic                      rd_take;
   bfs_pkg::bfs_sel_t         sel;
   logic                      fail_reg;
   logic                      busy_reg;
   logic                      ise_reg;
   logic                      rsv_reg;
   logic                      stop_seen_reg;
   logic                      op_prev_reg;
   logic                      op_rise;
   logic                      line_start;
   logic                      line_stop;
   logic                      det_start;
   logic                      det_stop;
   logic                      fail_evt;
   logic                      cfg_wr;
   logic [1:0]                cfg_mask;
   logic [1:0]                cfg_val;
   logic [bfs_pkg::EV_NUM-1:0] irq_sts_reg;
   logic [bfs_pkg::EV_NUM-1:0] irq_en_reg;
   logic [bfs_pkg::EV_NUM-1:0] irq_evt;
   logic [bfs_pkg::EV_NUM-1:0] irq_clr;
   logic [7:0]                flag_view;

   // address decode, shared by the read mux and the write strobes
   function automatic bfs_pkg::bfs_sel_t decode(input logic [31:0] a);
      bfs_pkg::bfs_sel_t s;
      s = bfs_pkg::SEL_NONE;
      unique case (a)
         bfs_pkg::FLAG_ADDR:    s = bfs_pkg::SEL_FLAG;
         bfs_pkg::STATE_ADDR:   s = bfs_pkg::SEL_STATE;
         bfs_pkg::IRQ_STS_ADDR: s = bfs_pkg::SEL_IRQ_STS;
         bfs_pkg::IRQ_CLR_ADDR: s = bfs_pkg::SEL_IRQ_CLR;
         bfs_pkg::IRQ_EN_ADDR:  s = bfs_pkg::SEL_IRQ_EN;
         bfs_pkg::BIT_ADDR:     s = bfs_pkg::SEL_BIT;
         default:               s = bfs_pkg::SEL_NONE;
      endcase
      return s;
   endfunction

   // bus line conditions
   bfs_line_watch u_watch (
      .clk        (clk),
      .rstn       (rstn),
      .scl_in     (scl_in),
      .sda_in     (sda_in),
      .start_seen (line_start),
      .stop_seen  (line_stop)
   );

   // conditions count only while the controller runs
   assign det_start = op_enable & line_start;
   assign det_stop  = op_enable & line_stop;

   // bus handshake: one wait cycle, then the access completes
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (read | write) & ~ack_reg;
      end
   end

   assign waitrequest = (read | write) & ~ack_reg;
   assign wr_fire     = write & ack_reg;
   assign rd_take     = read & ~ack_reg;
   assign sel         = decode(address);

   // byte write through lane 0, or single bit through the bit port
   always_comb begin
      cfg_mask = 2'b00;
      cfg_val  = 2'b00;
      if (sel == bfs_pkg::SEL_FLAG && byteenable[0]) begin
         cfg_mask = 2'b11;
         cfg_val  = {writedata[bfs_pkg::ISE_BIT], writedata[bfs_pkg::RSV_BIT]};
      end else if (sel == bfs_pkg::SEL_BIT && byteenable[0]) begin
         // a bit number of 6 or 7 matches nothing, so the write is lost
         cfg_mask[bfs_pkg::ISE_BIT] = (writedata[2:0] == 3'(bfs_pkg::ISE_BIT));
         cfg_mask[bfs_pkg::RSV_BIT] = (writedata[2:0] == 3'(bfs_pkg::RSV_BIT));
         cfg_val = {2{writedata[bfs_pkg::BIT_VAL_POS]}};
      end
   end

   // setup bit writes are ignored while the controller runs
   assign cfg_wr = wr_fire & ~op_enable;

   // reservation disable: software only
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rsv_reg <= bfs_pkg::FLAG_RESET[bfs_pkg::RSV_BIT];
      end else if (cfg_wr && cfg_mask[bfs_pkg::RSV_BIT]) begin
         rsv_reg <= cfg_val[bfs_pkg::RSV_BIT];
      end
   end

   assign reserve_enabled = ~rsv_reg;

   // initial start enable: set by software, cleared by a start condition
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ise_reg <= bfs_pkg::FLAG_RESET[bfs_pkg::ISE_BIT];
      end else if (cfg_wr && cfg_mask[bfs_pkg::ISE_BIT]) begin
         ise_reg <= cfg_val[bfs_pkg::ISE_BIT];
      end else if (det_start) begin
         ise_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         op_prev_reg <= 1'b0;
      end else begin
         op_prev_reg <= op_enable;
      end
   end

   assign op_rise = op_enable & ~op_prev_reg;

   // bus busy; a start in the same cycle as a stop leaves the bus busy
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         busy_reg <= bfs_pkg::FLAG_RESET[bfs_pkg::BUSY_BIT];
      end else if (!op_enable) begin
         busy_reg <= 1'b0;
      end else if (det_start || (op_rise && !ise_reg)) begin
         busy_reg <= 1'b1;
      end else if (det_stop) begin
         busy_reg <= 1'b0;
      end
   end

   // remembers a stop since enabling, the gate for the first start
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stop_seen_reg <= 1'b0;
      end else if (!op_enable || op_rise) begin
         stop_seen_reg <= 1'b0;
      end else if (det_stop) begin
         stop_seen_reg <= 1'b1;
      end
   end

   // the busy flag is the bus view; with initial start it reads released
   assign start_allowed = op_enable & ~busy_reg & (stop_seen_reg | ise_reg);

   // without reservation a start that cannot go out is dropped
   assign fail_evt = op_enable & start_req & rsv_reg & ~start_allowed;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fail_reg <= bfs_pkg::FLAG_RESET[bfs_pkg::FAIL_BIT];
      end else if (!op_enable) begin
         fail_reg <= 1'b0;
      end else if (fail_evt) begin
         fail_reg <= 1'b1;
      end else if (start_req) begin
         fail_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         start_trigger_clr <= 1'b0;
      end else begin
         start_trigger_clr <= fail_evt;
      end
   end

   // interrupts: sticky status, set beats a clear in the same cycle
   assign irq_evt[bfs_pkg::EV_START] = det_start;
   assign irq_evt[bfs_pkg::EV_STOP]  = det_stop;
   assign irq_evt[bfs_pkg::EV_FAIL]  = fail_evt;
   assign irq_clr = (wr_fire && sel == bfs_pkg::SEL_IRQ_CLR && byteenable[0])
                  ? writedata[bfs_pkg::EV_NUM-1:0] : '0;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_sts_reg <= bfs_pkg::IRQ_RESET;
      end else begin
         irq_sts_reg <= (irq_sts_reg & ~irq_clr) | irq_evt;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_en_reg <= bfs_pkg::IRQ_RESET;
      end else if (wr_fire && sel == bfs_pkg::SEL_IRQ_EN && byteenable[0]) begin
         irq_en_reg <= writedata[bfs_pkg::EV_NUM-1:0];
      end
   end

   assign irq = |(irq_sts_reg & irq_en_reg);

   // flag register image; bits 2 to 5 read zero
   always_comb begin
      flag_view = 8'h00;
      flag_view[bfs_pkg::FAIL_BIT] = fail_reg;
      flag_view[bfs_pkg::BUSY_BIT] = busy_reg;
      flag_view[bfs_pkg::ISE_BIT]  = ise_reg;
      flag_view[bfs_pkg::RSV_BIT]  = rsv_reg;
   end

   // read data captured in the wait cycle, held for the completing edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         readdata <= 32'h00000000;
      end else if (rd_take) begin
         unique case (sel)
            bfs_pkg::SEL_FLAG:    readdata <= {24'h000000, flag_view};
            bfs_pkg::SEL_STATE:   readdata <= {28'h0000000, start_allowed,
                                               stop_seen_reg, op_enable, ~rsv_reg};
            bfs_pkg::SEL_IRQ_STS: readdata <= {29'h00000000, irq_sts_reg};
            bfs_pkg::SEL_IRQ_EN:  readdata <= {29'h00000000, irq_en_reg};
            default:              readdata <= 32'h00000000;
         endcase
      end
   end

endmodule // bfs_flag_reg

//--- src/bfs_pkg.sv
// Purpose: shared constants for the bus flag and start setup block
// Assumes: 32-bit avalon-mm slave, byte addresses, one word per register
// Notes:   flag register sits at four times its printed index

package bfs_pkg;

   // register map
   localparam logic [31:0] FLAG_INDEX   = 32'h0ffffd8a;
   localparam logic [31:0] FLAG_ADDR    = {FLAG_INDEX[29:0], 2'b00};
   localparam logic [31:0] STATE_ADDR   = 32'h00000000;
   localparam logic [31:0] IRQ_STS_ADDR = 32'h00000004;
   localparam logic [31:0] IRQ_CLR_ADDR = 32'h00000008;
   localparam logic [31:0] IRQ_EN_ADDR  = 32'h0000000c;
   localparam logic [31:0] BIT_ADDR     = 32'h00000010;

   // flag register fields
   localparam int FAIL_BIT = 7;
   localparam int BUSY_BIT = 6;
   localparam int ISE_BIT  = 1;
   localparam int RSV_BIT  = 0;
   localparam logic [7:0] FLAG_RESET = 8'h00;

   // bit access register fields
   localparam int BIT_VAL_POS = 8;

   // interrupt sources
   localparam int EV_START = 0;
   localparam int EV_STOP  = 1;
   localparam int EV_FAIL  = 2;
   localparam int EV_NUM   = 3;
   localparam logic [EV_NUM-1:0] IRQ_RESET = 3'h0;

   // synchroniser depth for bus lines
   localparam int SYNC_STAGES = 2;

   typedef enum {
      SEL_NONE,
      SEL_FLAG,
      SEL_STATE,
      SEL_IRQ_STS,
      SEL_IRQ_CLR,
      SEL_IRQ_EN,
      SEL_BIT
   } bfs_sel_t;

endpackage

//--- src/bfs_line_watch.sv
// Purpose: find start and stop conditions on the two bus lines
// Assumes: lines are asynchronous to clk and much slower than it
// Notes:   outputs are one-cycle pulses, three clocks after the line edge
`timescale 1ns/1ps

module bfs_line_watch (
   // clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // bus lines
   input  wire logic scl_in,
   input  wire logic sda_in,
   // detected conditions
   output logic      start_seen,
   output logic      stop_seen
);

   logic [bfs_pkg::SYNC_STAGES-1:0] scl_sync_reg;
   logic [bfs_pkg::SYNC_STAGES-1:0] sda_sync_reg;
   logic                            scl_prev_reg;
   logic                            sda_prev_reg;
   logic                            scl_s;
   logic                            sda_s;

   // the first stage feeds only the next stage
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         scl_sync_reg <= '1;
         sda_sync_reg <= '1;
      end else begin
         scl_sync_reg <= {scl_sync_reg[bfs_pkg::SYNC_STAGES-2:0], scl_in};
         sda_sync_reg <= {sda_sync_reg[bfs_pkg::SYNC_STAGES-2:0], sda_in};
      end
   end

   assign scl_s = scl_sync_reg[bfs_pkg::SYNC_STAGES-1];
   assign sda_s = sda_sync_reg[bfs_pkg::SYNC_STAGES-1];

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         scl_prev_reg <= scl_s;
         sda_prev_reg <= sda_s;
      end
   end

   // data moving while the clock line stays high marks a condition
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         start_seen <= 1'b0;
         stop_seen  <= 1'b0;
      end else begin
         start_seen <= scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
         stop_seen  <= scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
      end
   end

endmodule // bfs_line_watch

//--- verif/bfs_flag_reg_monitor.sv
// Purpose: port assertions for the flag register block
// Assumes: one clk domain, rstn async active low
// Notes:   register contents are judged by the bench
`timescale 1ns/1ps

module bfs_flag_reg_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // bus
   input wire logic read,
   input wire logic write,
   input wire logic waitrequest,
   // controller
   input wire logic op_enable,
   input wire logic start_req,
   input wire logic start_trigger_clr,
   input wire logic start_allowed,
   input wire logic reserve_enabled
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   AST_WAIT_FIRST: assert property ($rose(read | write) |-> waitrequest)
      else $error("access without wait cycle");
   AST_WAIT_ONE: assert property ((read | write) && waitrequest |=> !waitrequest)
      else $error("wait longer than one cycle");
   AST_CLR_PULSE: assert property (start_trigger_clr |=> !start_trigger_clr)
      else $error("trigger clear longer than a pulse");
   AST_CLR_CAUSE: assert property (start_trigger_clr |-> $past(start_req) || $past(start_req, 2))
      else $error("trigger clear without start request");
   AST_NO_FAIL_RSV: assert property (start_req && reserve_enabled |=> !start_trigger_clr [*2])
      else $error("failure raised with reservation on");
   AST_FAIL_BLOCK: assert property (start_req && op_enable && !reserve_enabled && !start_allowed
      |-> ##[1:2] start_trigger_clr)
      else $error("blocked start not reported");
   // start may only be offered while running
   AST_ALLOW_OP: assert property (start_allowed |-> op_enable)
      else $error("start allowed while stopped");
   AST_RSV_STABLE: assert property (op_enable |=> $stable(reserve_enabled))
      else $error("reservation changed while running");
endmodule // bfs_flag_reg_monitor

bind bfs_flag_reg bfs_flag_reg_monitor bfs_flag_reg_monitor_i (.clk(clk), .rstn(rstn),
   .read(read), .write(write), .waitrequest(waitrequest), .op_enable(op_enable),
   .start_req(start_req), .start_trigger_clr(start_trigger_clr),
   .start_allowed(start_allowed), .reserve_enabled(reserve_enabled));

//--- verif/bfs_bus_model.sv
// Purpose: foreign bus party making start and stop conditions
// Assumes: lines pulled high when released, 125 ns bus clock
// Notes:   only conditions are modelled, no data bytes
`timescale 1ns/1ps

module bfs_bus_model (
   // bus lines
   output logic scl,
   output logic sda
);
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // non-blocking, so a line edge on a clock edge never races the sampling flop
   task automatic start_cond();
      sda <= 1'b0;
      #62.5 scl <= 1'b0;
   endtask
   // sda is pulled low under scl low first, so a stop also works from idle
   task automatic stop_cond();
      scl <= 1'b0;
      #31.25 sda <= 1'b0;
      #31.25 scl <= 1'b1;
      #62.5 sda <= 1'b1;
   endtask
endmodule // bfs_bus_model

//--- verif/testbench.sv
// Purpose: register and controller tests of the flag register block
// Assumes: one wait cycle per access, bus conditions from the model
// Notes:   lane 0 carries all register data except the bit port value, bit 8 in lane 1
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin failures++; \
   $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end

module testbench;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic [31:0] address = 32'h0;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [3:0]  byteenable = 4'h1;
   logic        op_enable = 1'b0;
   logic        start_req = 1'b0;
   logic [31:0] readdata, q;
   logic        waitrequest, scl, sda, clr, allowed, rsv_on, irq, seen;
   int          failures = 0;
   int          total_checks = 0;

   always #5 clk = ~clk;

   bfs_bus_model bfs_bus_model_i (.scl(scl), .sda(sda));
   bfs_flag_reg bfs_flag_reg_i (.clk(clk), .rstn(rstn), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .scl_in(scl), .sda_in(sda), .op_enable(op_enable),
      .start_req(start_req), .start_trigger_clr(clr), .start_allowed(allowed),
      .reserve_enabled(rsv_on), .irq(irq));

   task automatic summarize();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic acc(input logic wr, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      address <= a;
      writedata <= d;
      read <= ~wr;
      write <= wr;
      do begin
         @(negedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         failures++;
         summarize();
      end
      @(posedge clk);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic chk(input logic [31:0] a, input logic [7:0] e, input string nm);
      acc(1'b0, a, 32'h0);
      `CHK(nm, e, q[7:0])
   endtask

   task automatic op(input logic v);
      @(posedge clk);
      op_enable <= v;
      repeat (2) @(posedge clk);
   endtask

   // failure pulse may land one or two cycles after the request
   task automatic pulse();
      @(posedge clk);
      start_req <= 1'b1;
      @(posedge clk);
      start_req <= 1'b0;
      @(negedge clk);
      seen = clr;
      @(negedge clk);
      seen = seen | clr;
   endtask

   task automatic line(input bit s);
      if (s)
         bfs_bus_model_i.start_cond();
      else
         bfs_bus_model_i.stop_cond();
      repeat (6) @(posedge clk);
      @(negedge clk);
   endtask

   initial begin
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      chk(bfs_pkg::FLAG_ADDR, 8'h00, "flag reset");
      `CHK("rsv on", 1'b1, rsv_on)
      $display("test 1 done");
      acc(1'b1, bfs_pkg::FLAG_ADDR, 32'hff);
      chk(bfs_pkg::FLAG_ADDR, 8'h03, "byte write");
      acc(1'b1, bfs_pkg::BIT_ADDR, 32'h001);
      chk(bfs_pkg::FLAG_ADDR, 8'h01, "bit clear");
      acc(1'b1, bfs_pkg::BIT_ADDR, 32'h107);
      chk(bfs_pkg::FLAG_ADDR, 8'h01, "bit7 write");
      acc(1'b1, bfs_pkg::BIT_ADDR, 32'h101);
      chk(bfs_pkg::FLAG_ADDR, 8'h03, "bit set");
      chk(32'h100, 8'h00, "unmapped");
      @(posedge clk);
      byteenable <= 4'h0;
      acc(1'b1, bfs_pkg::FLAG_ADDR, 32'h0);
      byteenable <= 4'h1;
      chk(bfs_pkg::FLAG_ADDR, 8'h03, "lane off");
      acc(1'b1, bfs_pkg::BIT_ADDR, 32'h000);
      $display("test 2 done");
      acc(1'b1, bfs_pkg::IRQ_EN_ADDR, 32'h1);
      op(1'b1);
      chk(bfs_pkg::FLAG_ADDR, 8'h02, "init free");
      `CHK("allowed", 1'b1, allowed)
      acc(1'b1, bfs_pkg::FLAG_ADDR, 32'h01);
      chk(bfs_pkg::FLAG_ADDR, 8'h02, "locked");
      line(1'b1);
      chk(bfs_pkg::FLAG_ADDR, 8'h40, "start seen");
      `CHK("irq", 1'b1, irq)
      acc(1'b1, bfs_pkg::IRQ_CLR_ADDR, 32'h1);
      acc(1'b1, bfs_pkg::IRQ_EN_ADDR, 32'h0);
      line(1'b0);
      `CHK("irq masked", 1'b0, irq)
      chk(bfs_pkg::IRQ_STS_ADDR, 8'h02, "status");
      chk(bfs_pkg::FLAG_ADDR, 8'h00, "stop seen");
      `CHK("allowed", 1'b1, allowed)
      chk(bfs_pkg::STATE_ADDR, 8'h0f, "state");
      op(1'b0);
      $display("test 3 done");
      acc(1'b1, bfs_pkg::FLAG_ADDR, 32'h01);
      @(negedge clk);
      `CHK("rsv off", 1'b0, rsv_on)
      op(1'b1);
      `CHK("blocked", 1'b0, allowed)
      pulse();
      `CHK("trig clr", 1'b1, seen)
      chk(bfs_pkg::FLAG_ADDR, 8'hc1, "failed");
      chk(bfs_pkg::IRQ_STS_ADDR, 8'h06, "fail event");
      op(1'b0);
      chk(bfs_pkg::FLAG_ADDR, 8'h01, "op off");
      op(1'b1);
      pulse();
      line(1'b0);
      chk(bfs_pkg::FLAG_ADDR, 8'h81, "released");
      pulse();
      `CHK("no clr", 1'b0, seen)
      chk(bfs_pkg::FLAG_ADDR, 8'h01, "retrig");
      op(1'b0);
      $display("test 4 done");
      acc(1'b1, bfs_pkg::BIT_ADDR, 32'h000);
      op(1'b1);
      pulse();
      `CHK("reserved", 1'b0, seen)
      chk(bfs_pkg::FLAG_ADDR, 8'h40, "no fail");
      op(1'b0);
      acc(1'b1, bfs_pkg::FLAG_ADDR, 32'h03);
      chk(bfs_pkg::FLAG_ADDR, 8'h03, "setup set");
      @(posedge clk);
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      chk(bfs_pkg::FLAG_ADDR, 8'h00, "flag rerst");
      `CHK("rsv reset", 1'b1, rsv_on)
      $display("test 5 done");
      summarize();
   end
endmodule // testbench
